// ---- shared/devcap_defines.svh ----
// offsets, field positions, reset values of the device capability/control block
`ifndef DEVCAP_DEFINES_SVH
`define DEVCAP_DEFINES_SVH

// register byte addresses
`define CAP_OFFSET          12'h0e4
`define CTRL_OFFSET         12'h0e8
`define MASK_OFFSET         12'h100

// capability word field positions
`define CAP_PAYLOAD_LSB     0
`define CAP_L0S_LSB         6
`define CAP_L1_LSB          9
`define CAP_ROLE_BIT        15
`define CAP_PWR_VAL_LSB     18
`define CAP_PWR_SCALE_LSB   26

// control word field positions
`define CTRL_ERR_LSB        0
`define CTRL_RELAX_BIT      4
`define CTRL_PAYLOAD_LSB    5
`define CTRL_AUX_BIT        10
`define STAT_LSB            16

// reset values
`define CAP_PAYLOAD_RESET   3'h1
`define CAP_L0S_RESET       3'h0
`define CAP_L1_RESET        3'h0
`define CAP_ROLE_RESET      1'h1
`define CAP_PWR_VAL_RESET   8'h00
`define CAP_PWR_SCALE_RESET 2'h0
`define CTRL_ERR_RESET      4'h0
`define CTRL_RELAX_RESET    1'h1
`define CTRL_PAYLOAD_RESET  3'h0
`define CTRL_AUX_RESET      1'h0
`define STAT_RESET          4'h0
`define MASK_RESET          4'h0

`endif

// ---- shared/devcap_pkg.sv ----
// types shared by the device capability/control block
package devcap_pkg;
  typedef logic [2:0]  payload_code_type;
  typedef logic [3:0]  err_vec_type;
  typedef logic [31:0] word_type;
  typedef enum logic {preload_capability, preload_control} preload_target_type;
endpackage

// ---- hdl/pcie_device_cap_ctrl_regs.sv ----
// device capability and control register pair with apb access and error interrupt
//
// Notes on behaviour
// R01: payload capacity field reads 001b, meaning 256-byte payloads, unless preloaded.
// R02: phantom, extended tag, attention and power indicator bits read zero.
// R03: read-only standby exit latency field, resets to 000b.
// R04: read-only deep sleep exit latency field, resets to 000b.
// R05: read-only role-based error reporting bit, default value is loadable.
// R06: slot power limit message value is captured into bits 25:18.
// R07: slot power limit message scale is captured into bits 27:26, resets 00b.
// R08: four writable error reporting enables, one each, reset to zero.
// R09: payload limit writes above capacity are clamped; field resets to 000b.
// R10: extended tag, phantom and no-snoop enables read zero always.
// R11: read-only aux power enable bit, resets to zero.
// R12: loadable fields take defaults from the smbus or eeprom preload port.
// R13: writes to read-only, hardwired and reserved fields are ignored.
// R14: relaxed ordering enable is read-write and resets to one.
// R15: error detected flags set on every error, whatever the enables say.
`timescale 1ns/1ns
`include "devcap_defines.svh"

module pcie_device_cap_ctrl_regs #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [ADDR_WIDTH-1:0]   paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    preload_valid,
  input  wire devcap_pkg::preload_target_type preload_target,
  input  wire logic [31:0]             preload_data,
  input  wire logic                    slot_msg_valid,
  input  wire logic [7:0]              slot_msg_value,
  input  wire logic [1:0]              slot_msg_scale,
  input  wire logic [3:0]              err_detect,
  output logic                         irq,
  output logic [3:0]                   report_enable,
  output logic                         relaxed_order_enable,
  output logic [2:0]                   payload_limit,
  output logic                         aux_power_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // byte strobes to a bit mask
  function automatic devcap_pkg::word_type byte_mask(input logic [3:0] strb);
    devcap_pkg::word_type m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // limit a requested payload code to the advertised capacity
  function automatic devcap_pkg::payload_code_type clamp_payload(
    input devcap_pkg::payload_code_type req,
    input devcap_pkg::payload_code_type cap
  );
    return (req > cap) ? cap : req; // R09
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  devcap_pkg::payload_code_type cap_payload;
  devcap_pkg::payload_code_type next_cap_payload;
  logic [2:0]                   cap_l0s;
  logic [2:0]                   next_cap_l0s;
  logic [2:0]                   cap_l1;
  logic [2:0]                   next_cap_l1;
  logic                         cap_role;
  logic                         next_cap_role;
  logic [7:0]                   cap_pwr_val;
  logic [7:0]                   next_cap_pwr_val;
  logic [1:0]                   cap_pwr_scale;
  logic [1:0]                   next_cap_pwr_scale;
  devcap_pkg::err_vec_type      err_en;
  devcap_pkg::err_vec_type      next_err_en;
  logic                         relax_en;
  logic                         next_relax_en;
  devcap_pkg::payload_code_type ctl_payload;
  devcap_pkg::payload_code_type next_ctl_payload;
  logic                         aux_en;
  logic                         next_aux_en;
  devcap_pkg::err_vec_type      err_status;
  devcap_pkg::err_vec_type      next_err_status;
  devcap_pkg::err_vec_type      err_mask;
  devcap_pkg::err_vec_type      next_err_mask;

  // bus answer state
  logic [31:0]                  next_prdata;
  logic                         next_pready;
  logic                         next_pslverr;
  logic                         next_irq;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and word images

  logic                         hit_cap;
  logic                         hit_ctrl;
  logic                         hit_mask;
  logic                         hit_any;
  logic                         wr_commit;
  devcap_pkg::word_type         wmask;
  devcap_pkg::word_type         wr_bits;
  devcap_pkg::word_type         cap_word;
  devcap_pkg::word_type         ctrl_word;
  devcap_pkg::word_type         mask_word;

  assign hit_cap   = (paddr == ADDR_WIDTH'(`CAP_OFFSET));
  assign hit_ctrl  = (paddr == ADDR_WIDTH'(`CTRL_OFFSET));
  assign hit_mask  = (paddr == ADDR_WIDTH'(`MASK_OFFSET));
  assign hit_any   = hit_cap | hit_ctrl | hit_mask;
  // a write lands only on the edge that samples pready high
  assign wr_commit = psel & penable & pready & pwrite;
  assign wmask     = byte_mask(pstrb);
  assign wr_bits   = pwdata & wmask;

  // capability word, unimplemented and reserved bits fixed at zero
  always_comb begin
    cap_word = 32'h0000_0000; // R02
    cap_word[`CAP_PAYLOAD_LSB +: 3]   = cap_payload; // R01
    cap_word[`CAP_L0S_LSB +: 3]       = cap_l0s; // R03
    cap_word[`CAP_L1_LSB +: 3]        = cap_l1; // R04
    cap_word[`CAP_ROLE_BIT]           = cap_role; // R05
    cap_word[`CAP_PWR_VAL_LSB +: 8]   = cap_pwr_val; // R06
    cap_word[`CAP_PWR_SCALE_LSB +: 2] = cap_pwr_scale; // R07
  end

  // control word with detected flags in the upper half
  always_comb begin
    ctrl_word = 32'h0000_0000; // R10
    ctrl_word[`CTRL_ERR_LSB +: 4]     = err_en;
    ctrl_word[`CTRL_RELAX_BIT]        = relax_en;
    ctrl_word[`CTRL_PAYLOAD_LSB +: 3] = ctl_payload;
    ctrl_word[`CTRL_AUX_BIT]          = aux_en; // R11
    ctrl_word[`STAT_LSB +: 4]         = err_status;
  end

  // interrupt mask word, same layout as the flags
  always_comb begin
    mask_word = 32'h0000_0000;
    mask_word[`STAT_LSB +: 4] = err_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // capability fields: preload and slot power message

  always_comb begin
    next_cap_payload   = cap_payload;
    next_cap_l0s       = cap_l0s;
    next_cap_l1        = cap_l1;
    next_cap_role      = cap_role;
    next_cap_pwr_val   = cap_pwr_val;
    next_cap_pwr_scale = cap_pwr_scale;
    // bus writes never reach this word
    if (preload_valid && preload_target == devcap_pkg::preload_capability) begin // R12
      next_cap_payload   = preload_data[`CAP_PAYLOAD_LSB +: 3];
      next_cap_l0s       = preload_data[`CAP_L0S_LSB +: 3];
      next_cap_l1        = preload_data[`CAP_L1_LSB +: 3];
      next_cap_role      = preload_data[`CAP_ROLE_BIT];
      next_cap_pwr_val   = preload_data[`CAP_PWR_VAL_LSB +: 8];
      next_cap_pwr_scale = preload_data[`CAP_PWR_SCALE_LSB +: 2];
    end
    // a received message overrides the loaded power limit
    if (slot_msg_valid) begin
      next_cap_pwr_val   = slot_msg_value; // R06
      next_cap_pwr_scale = slot_msg_scale; // R07
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_payload   <= `CAP_PAYLOAD_RESET; // R01
      cap_l0s       <= `CAP_L0S_RESET; // R03
      cap_l1        <= `CAP_L1_RESET; // R04
      cap_role      <= `CAP_ROLE_RESET; // R05
      cap_pwr_val   <= `CAP_PWR_VAL_RESET;
      cap_pwr_scale <= `CAP_PWR_SCALE_RESET; // R07
    end else begin
      cap_payload   <= next_cap_payload;
      cap_l0s       <= next_cap_l0s;
      cap_l1        <= next_cap_l1;
      cap_role      <= next_cap_role;
      cap_pwr_val   <= next_cap_pwr_val;
      cap_pwr_scale <= next_cap_pwr_scale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields: software writes, preload takes priority

  always_comb begin
    next_err_en      = err_en;
    next_relax_en    = relax_en;
    next_ctl_payload = ctl_payload;
    next_aux_en      = aux_en;
    // only the writable bits are merged, the rest is dropped
    if (wr_commit && hit_ctrl) begin // R13
      if (pstrb[0]) begin
        next_err_en      = pwdata[`CTRL_ERR_LSB +: 4]; // R08
        next_relax_en    = pwdata[`CTRL_RELAX_BIT]; // R14
        next_ctl_payload = clamp_payload(pwdata[`CTRL_PAYLOAD_LSB +: 3], cap_payload); // R09
      end
    end
    if (preload_valid && preload_target == devcap_pkg::preload_control) begin // R12
      next_err_en      = preload_data[`CTRL_ERR_LSB +: 4];
      next_ctl_payload = clamp_payload(preload_data[`CTRL_PAYLOAD_LSB +: 3], cap_payload);
      next_aux_en      = preload_data[`CTRL_AUX_BIT]; // R11
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_en      <= `CTRL_ERR_RESET; // R08
      relax_en    <= `CTRL_RELAX_RESET; // R14
      ctl_payload <= `CTRL_PAYLOAD_RESET; // R09
      aux_en      <= `CTRL_AUX_RESET; // R11
    end else begin
      err_en      <= next_err_en;
      relax_en    <= next_relax_en;
      ctl_payload <= next_ctl_payload;
      aux_en      <= next_aux_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detected flags, mask and interrupt

  always_comb begin
    next_err_status = err_status;
    next_err_mask   = err_mask;
    // write one to clear
    if (wr_commit && hit_ctrl) begin
      next_err_status = err_status & ~wr_bits[`STAT_LSB +: 4];
    end
    // a new error wins over a clear in the same cycle
    next_err_status = next_err_status | err_detect; // R15
    if (wr_commit && hit_mask) begin
      next_err_mask = (err_mask & ~wmask[`STAT_LSB +: 4]) | wr_bits[`STAT_LSB +: 4];
    end
    next_irq = |(next_err_status & next_err_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_status <= `STAT_RESET;
      err_mask   <= `MASK_RESET;
      irq        <= 1'b0;
    end else begin
      err_status <= next_err_status;
      err_mask   <= next_err_mask;
      irq        <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, data and error registered

  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !hit_any;
      if (!pwrite) begin
        if (hit_cap) begin
          next_prdata = cap_word;
        end else if (hit_ctrl) begin
          next_prdata = ctrl_word;
        end else if (hit_mask) begin
          next_prdata = mask_word;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs, registered copies of the fields

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      report_enable        <= `CTRL_ERR_RESET;
      relaxed_order_enable <= `CTRL_RELAX_RESET;
      payload_limit        <= `CTRL_PAYLOAD_RESET;
      aux_power_enable     <= `CTRL_AUX_RESET;
    end else begin
      report_enable        <= next_err_en; // R08
      relaxed_order_enable <= next_relax_en;
      payload_limit        <= next_ctl_payload;
      aux_power_enable     <= next_aux_en;
    end
  end

endmodule // pcie_device_cap_ctrl_regs

// ---- tb/devcap_monitor.sv ----
// assertion checker for the capability/control register pair
`timescale 1ns/1ns
`include "devcap_defines.svh"
module devcap_monitor #(
  parameter int ADDR_WIDTH = 12
) (
  input logic                  clk,
  input logic                  reset,
  input logic [ADDR_WIDTH-1:0] paddr,
  input logic                  psel,
  input logic                  penable,
  input logic                  pwrite,
  input logic [31:0]           pwdata,
  input logic [3:0]            pstrb,
  input logic [31:0]           prdata,
  input logic                  pready,
  input logic                  pslverr,
  input logic                  preload_valid,
  input logic [3:0]            err_detect,
  input logic                  irq,
  input logic [3:0]            report_enable,
  input logic                  relaxed_order_enable,
  input logic [2:0]            payload_limit,
  input logic                  aux_power_enable
);
  // decoded bus events
  wire acc = psel && penable && !pready;
  wire ctl = paddr == `CTRL_OFFSET;
  wire map = ctl || paddr == `CAP_OFFSET || paddr == `MASK_OFFSET;
  wire wr_ctl = pready && pwrite && ctl && pstrb[0];
  wire cause = |err_detect || pready && pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  // bus answers
  answer_wait_a: assert property (acc |=> pready ##1 !pready)
    else $error("bad answer timing");
  unmapped_err_a: assert property (acc && !map |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("data or error outside answer");
  cap_zeros_a: assert property (pready && !pwrite && paddr == `CAP_OFFSET |->
    (prdata & 32'hf003_7038) == 32'h0) else $error("hardwired capability bit set");
  ctrl_view_a: assert property (pready && !pwrite && ctl && !$past(preload_valid) |->
    prdata[15:0] == {5'h0, aux_power_enable, 2'h0, payload_limit, relaxed_order_enable,
    report_enable}) else $error("control read differs from outputs");
  //////////////////////////////////////////////////////////////////////////////
  // field updates
  enable_write_a: assert property (wr_ctl && !preload_valid |=>
    report_enable == $past(pwdata[3:0])) else $error("enables not written");
  clamp_down_a: assert property (wr_ctl && !preload_valid |=>
    payload_limit <= $past(pwdata[7:5])) else $error("payload limit above written value");
  aux_ro_a: assert property ($changed(aux_power_enable) |-> $past(preload_valid))
    else $error("aux enable changed by bus");
  relax_rw_a: assert property ($changed(relaxed_order_enable) |-> $past(wr_ctl))
    else $error("relaxed ordering changed without write");
  irq_cause_a: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
    else $error("interrupt without cause");
endmodule // devcap_monitor

bind pcie_device_cap_ctrl_regs devcap_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon (
  .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .preload_valid(preload_valid), .err_detect(err_detect), .irq(irq),
  .report_enable(report_enable), .relaxed_order_enable(relaxed_order_enable),
  .payload_limit(payload_limit), .aux_power_enable(aux_power_enable)
);

// ---- tb/link_event_source.sv ----
// far-side model: slot power limit messages and error events
`timescale 1ns/1ns
module link_event_source (
  input  logic       clk,
  output logic       slot_msg_valid,
  output logic [7:0] slot_msg_value,
  output logic [1:0] slot_msg_scale,
  output logic [3:0] err_detect
);
  // quiet link at time zero
  initial begin
    slot_msg_valid = 1'b0;
    slot_msg_value = 8'h5a;
    slot_msg_scale = 2'h1;
    err_detect = 4'h0;
  end
  // one-cycle message, fields inverted once stale
  task automatic send_slot(input logic [7:0] v, input logic [1:0] s);
    @(posedge clk);
    slot_msg_valid <= 1'b1;
    slot_msg_value <= v;
    slot_msg_scale <= s;
    @(posedge clk);
    slot_msg_valid <= 1'b0;
    slot_msg_value <= ~v;
    slot_msg_scale <= ~s;
  endtask
  // one-cycle error pulses
  task automatic send_err(input logic [3:0] e);
    @(posedge clk);
    err_detect <= e;
    @(posedge clk);
    err_detect <= 4'h0;
  endtask
endmodule // link_event_source

// ---- tb/tb_pcie_device_cap_ctrl_regs.sv ----
// self-checking bench for the capability/control register pair
`timescale 1ns/1ns
`include "devcap_defines.svh"
module tb_pcie_device_cap_ctrl_regs;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        preload_valid = 1'b0;
  logic [31:0] preload_data = 32'h0;
  logic [31:0] prdata, d, x;
  logic [7:0]  slot_msg_value, v;
  logic [1:0]  slot_msg_scale, s;
  logic [3:0]  err_detect, report_enable, e;
  logic [2:0]  payload_limit;
  logic        pready, pslverr, irq, slot_msg_valid, relaxed_order_enable, aux_power_enable;
  logic [32:0] notes[$];
  integer      seed = 44;
  int          fail_count = 0;
  int          checks = 0;
  devcap_pkg::preload_target_type preload_target = devcap_pkg::preload_capability;

  pcie_device_cap_ctrl_regs dut (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .preload_valid(preload_valid), .preload_target(preload_target),
    .preload_data(preload_data), .slot_msg_valid(slot_msg_valid),
    .slot_msg_value(slot_msg_value), .slot_msg_scale(slot_msg_scale),
    .err_detect(err_detect), .irq(irq), .report_enable(report_enable),
    .relaxed_order_enable(relaxed_order_enable), .payload_limit(payload_limit),
    .aux_power_enable(aux_power_enable)
  );
  link_event_source src (
    .clk(clk), .slot_msg_valid(slot_msg_valid), .slot_msg_value(slot_msg_value),
    .slot_msg_scale(slot_msg_scale), .err_detect(err_detect)
  );
  //////////////////////////////////////////////////////////////////////////////
  // clock, comparison and apb master
  always #25 clk = ~clk;
  always @(posedge clk)
    if (psel && penable && pready === 1'b1) check({pslverr, prdata}, notes.pop_front());
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     input logic [3:0] st, input logic [32:0] ex);
    notes.push_back(ex);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer as long as it takes, the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0, 4'hf, {1'b0, ex});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd, 4'hf, 33'h0);
  endtask
  task automatic preload(input devcap_pkg::preload_target_type t, input logic [31:0] pd);
    @(posedge clk);
    preload_valid <= 1'b1;
    preload_target <= t;
    preload_data <= pd;
    @(posedge clk);
    preload_valid <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    final_report;
  end
  // test sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(`CAP_OFFSET, 32'h0000_8001);
    rd(`CTRL_OFFSET, 32'h0000_0010);
    wr(`CAP_OFFSET, 32'hffff_ffff);
    rd(`CAP_OFFSET, 32'h0000_8001);
    $display("test end: reset values");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 3) ? 32'h0 : $random(seed);
      x = {24'h0, (d[7:5] > 3'h1) ? 3'h1 : d[7:5], d[4:0]};
      wr(`CTRL_OFFSET, d);
      rd(`CTRL_OFFSET, x);
      check(33'({payload_limit, relaxed_order_enable, report_enable}), 33'(x[7:0]));
    end
    apb(12'h0f0, 1'b0, 32'h0, 4'hf, {1'b1, 32'h0});
    apb(12'h0f0, 1'b1, 32'hffff_ffff, 4'hf, {1'b1, 32'h0});
    $display("test end: control writes");
    v = 8'($random(seed));
    s = 2'($random(seed));
    src.send_slot(v, s);
    rd(`CAP_OFFSET, {4'h0, s, v, 18'h0_8001});
    e = 4'($random(seed)) | 4'h1;
    src.send_err(e);
    rd(`CTRL_OFFSET, {12'h0, e, 16'h0});
    check(33'(irq), 33'h0);
    wr(`MASK_OFFSET, 32'h000f_0000);
    rd(`MASK_OFFSET, 32'h000f_0000);
    check(33'(irq), 33'h1);
    apb(`CTRL_OFFSET, 1'b1, {12'h0, e, 16'h0}, 4'h4, 33'h0);
    rd(`CTRL_OFFSET, 32'h0);
    check(33'(irq), 33'h0);
    $display("test end: slot message and errors");
    preload(devcap_pkg::preload_control, 32'h0000_04ef);
    rd(`CTRL_OFFSET, 32'h0000_042f);
    check(33'(aux_power_enable), 33'h1);
    preload(devcap_pkg::preload_capability, 32'hffff_ffc2);
    rd(`CAP_OFFSET, 32'h0ffc_8fc2);
    wr(`CTRL_OFFSET, 32'h0000_00e0);
    rd(`CTRL_OFFSET, 32'h0000_0440);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`CTRL_OFFSET, 32'h0000_0010);
    check(33'({aux_power_enable, payload_limit, relaxed_order_enable, report_enable}), 33'h010);
    rd(`CAP_OFFSET, 32'h0000_8001);
    $display("test end: preload and reset");
    final_report;
  end
endmodule // tb_pcie_device_cap_ctrl_regs
